// *** hdl/epi_pkg.sv ***
// Package for the external pin interrupt unit: register map, fields, sense modes, carriers
package epi_pkg;
  localparam int REG_AW = 4;
  localparam logic [3:0] OFS_SENSE_CONTROL = 4'h0;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] OFS_IRQ_FLAGS = 4'h2;
  localparam logic [3:0] OFS_GROUP_ENABLE = 4'h3;
  localparam logic [3:0] OFS_GROUP_FLAGS = 4'h4;
  localparam logic [3:0] OFS_MASK_GROUP0 = 4'h5;
  localparam logic [3:0] OFS_MASK_GROUP1 = 4'h6;
  localparam logic [3:0] OFS_MASK_GROUP2 = 4'h7;
  localparam logic [3:0] OFS_MASK_GROUP3 = 4'h8;
  localparam int SENSE1_LSB = 2;
  localparam int SENSE0_LSB = 0;
  localparam int NUM_EXT = 2;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_CHANGE_PINS = 28;
  localparam int GROUP3_PINS = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'b00,
    EPI_SENSE_ANY = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epi_bus_req_type;

  // Request lines toward the core: ext[1:0], groups[3:0]
  typedef struct packed {
    logic [3:0] group_req;
    logic [1:0] ext_req;
  } epi_req_type;

  typedef struct packed {
    logic [3:0] group_ack;
    logic [1:0] ext_ack;
  } epi_ack_type;
endpackage

// *** hdl/epi_unit.sv ***
// External pin interrupt unit: two sensed pins, four pin-change groups, register file
module epi_unit
  import epi_pkg::*;
(
  input wire logic clk, // 250 MHz I/O clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire epi_pkg::epi_bus_req_type bus_req, // Register request
  output logic [7:0] bus_rdata, // Read data, cycle after read strobe
  input wire logic [1:0] ext_pins, // Dedicated pins as seen at the pad, driven or not
  input wire logic [27:0] change_pins, // Pin-change inputs
  input wire logic global_irq_enable, // Global interrupt flag of cpu_status_word
  input wire epi_pkg::epi_ack_type ack, // Vector entry pulses per source
  output epi_pkg::epi_req_type req, // Vector requests per source
  output logic [1:0] ext_level_wake, // Unclocked low-level wake lines
  output logic [3:0] group_change_wake // Unclocked pin-change wake lines
);
  import epi_pkg::*;

  logic [3:0] sense_q;
  logic [1:0] ext_enable_q;
  logic [1:0] ext_flag_q;
  logic [1:0] ext_flag_d;
  logic [3:0] group_enable_q;
  logic [3:0] group_flag_q;
  logic [3:0] group_flag_d;
  logic [7:0] group0_pin_mask_q;
  logic [7:0] group1_pin_mask_q;
  logic [7:0] group2_pin_mask_q;
  logic [3:0] group3_pin_mask_q;
  logic [1:0] ext_samp_q;
  logic [1:0] ext_prev_q;
  logic [27:0] chg_samp_q;
  logic [27:0] chg_prev_q;
  logic [7:0] rdata_q;
  logic [1:0] ext_hit;
  logic [1:0] ext_is_level;
  logic [27:0] pin_mask;
  logic [3:0] group_hit;
  logic wr_en;

  function automatic epi_sense_type sense_of(input logic [3:0] s, input int idx);
    sense_of = epi_sense_type'(s[idx*2 +: 2]);
  endfunction

  function automatic logic group_any(input logic [27:0] v, input int g);
    logic r;
    r = 1'b0;
    unique case (g)
      0: r = |v[7:0];
      1: r = |v[15:8];
      2: r = |v[23:16];
      default: r = |v[27:24];
    endcase
    group_any = r;
  endfunction

  assign wr_en = bus_req.wr;

  // Pin inputs sampled once; edges compare two samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_samp_q <= 2'b11;
      ext_prev_q <= 2'b11;
    end else begin
      ext_samp_q <= ext_pins;
      ext_prev_q <= ext_samp_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_samp_q <= '0;
      chg_prev_q <= '0;
    end else begin
      chg_samp_q <= change_pins;
      chg_prev_q <= chg_samp_q;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_is_level[i] = (sense_of(sense_q, i) == EPI_SENSE_LOW);
      unique case (sense_of(sense_q, i))
        EPI_SENSE_LOW: ext_hit[i] = 1'b0;
        EPI_SENSE_ANY: ext_hit[i] = ext_samp_q[i] ^ ext_prev_q[i];
        EPI_SENSE_FALL: ext_hit[i] = ext_prev_q[i] & ~ext_samp_q[i];
        EPI_SENSE_RISE: ext_hit[i] = ~ext_prev_q[i] & ext_samp_q[i];
      endcase
    end
  end

  assign pin_mask = {group3_pin_mask_q, group2_pin_mask_q, group1_pin_mask_q, group0_pin_mask_q};

  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      group_hit[g] = group_enable_q[g] & group_any((chg_samp_q ^ chg_prev_q) & pin_mask, g);
    end
  end

  // Set wins over both clears so a coincident event is kept
  always_comb begin
    ext_flag_d = ext_flag_q;
    if (wr_en && bus_req.addr == OFS_IRQ_FLAGS) begin
      ext_flag_d = ext_flag_d & ~bus_req.wdata[1:0];
    end
    ext_flag_d = ext_flag_d & ~ack.ext_ack;
    ext_flag_d = (ext_flag_d | ext_hit) & ~ext_is_level;
  end

  always_comb begin
    group_flag_d = group_flag_q;
    if (wr_en && bus_req.addr == OFS_GROUP_FLAGS) begin
      group_flag_d = group_flag_d & ~bus_req.wdata[3:0];
    end
    group_flag_d = (group_flag_d & ~ack.group_ack) | group_hit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_flag_q <= RESET_BYTE[1:0];
      group_flag_q <= RESET_BYTE[3:0];
    end else begin
      ext_flag_q <= ext_flag_d;
      group_flag_q <= group_flag_d;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_q <= RESET_BYTE[3:0];
      ext_enable_q <= RESET_BYTE[1:0];
      group_enable_q <= RESET_BYTE[3:0];
      group0_pin_mask_q <= RESET_BYTE;
      group1_pin_mask_q <= RESET_BYTE;
      group2_pin_mask_q <= RESET_BYTE;
      group3_pin_mask_q <= RESET_BYTE[3:0];
    end else if (wr_en) begin
      unique case (bus_req.addr)
        OFS_SENSE_CONTROL: sense_q <= bus_req.wdata[3:0];
        OFS_IRQ_ENABLE: ext_enable_q <= bus_req.wdata[1:0];
        OFS_GROUP_ENABLE: group_enable_q <= bus_req.wdata[3:0];
        OFS_MASK_GROUP0: group0_pin_mask_q <= bus_req.wdata;
        OFS_MASK_GROUP1: group1_pin_mask_q <= bus_req.wdata;
        OFS_MASK_GROUP2: group2_pin_mask_q <= bus_req.wdata;
        OFS_MASK_GROUP3: group3_pin_mask_q <= bus_req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data registered; valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= READ_UNMAPPED;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_SENSE_CONTROL: rdata_q <= {4'h0, sense_q};
        OFS_IRQ_ENABLE: rdata_q <= {6'h00, ext_enable_q};
        OFS_IRQ_FLAGS: rdata_q <= {6'h00, ext_flag_q};
        OFS_GROUP_ENABLE: rdata_q <= {4'h0, group_enable_q};
        OFS_GROUP_FLAGS: rdata_q <= {4'h0, group_flag_q};
        OFS_MASK_GROUP0: rdata_q <= group0_pin_mask_q;
        OFS_MASK_GROUP1: rdata_q <= group1_pin_mask_q;
        OFS_MASK_GROUP2: rdata_q <= group2_pin_mask_q;
        OFS_MASK_GROUP3: rdata_q <= {4'h0, group3_pin_mask_q};
        default: rdata_q <= READ_UNMAPPED;
      endcase
    end else begin
      rdata_q <= READ_UNMAPPED;
    end
  end
  assign bus_rdata = rdata_q;

  // Low level requests straight from the sampled pin; the core must see it held
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      req.ext_req[i] = global_irq_enable & ext_enable_q[i] &
                       (ext_is_level[i] ? ~ext_samp_q[i] : ext_flag_q[i]);
    end
    req.group_req = group_flag_q & group_enable_q & {NUM_GROUPS{global_irq_enable}};
  end

  // Unclocked wake paths for sleep with the I/O clock stopped; not for vectoring
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_level_wake[i] = ext_enable_q[i] & ext_is_level[i] & ~ext_pins[i];
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      group_change_wake[g] = group_enable_q[g] & group_any((change_pins ^ chg_samp_q) & pin_mask, g);
    end
  end
endmodule

// *** tb/epi_unit_sva.sv ***
// Port checker of the pin interrupt unit
module epi_unit_sva
  import epi_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire epi_pkg::epi_bus_req_type bus_req, // Register request
  input wire logic [7:0] bus_rdata, // Read data
  input wire logic [1:0] ext_pins, // Dedicated pins
  input wire logic [27:0] change_pins, // Change pins
  input wire logic global_irq_enable, // Global flag
  input wire epi_pkg::epi_ack_type ack, // Entry pulses
  input wire epi_pkg::epi_req_type req, // Requests
  input wire logic [1:0] ext_level_wake, // Level wake
  input wire logic [3:0] group_change_wake // Change wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_RD_UNMAPPED: assert property ($past(bus_req.rd) && $past(bus_req.addr) > OFS_MASK_GROUP3 |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_EN_UPPER: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_IRQ_ENABLE |-> bus_rdata[7:2] == 6'h00)
    else $error("enable upper bits set");
  AST_GFLAG_UPPER: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_GROUP_FLAGS |-> bus_rdata[7:4] == 4'h0)
    else $error("group flag upper bits set");
  AST_REQ_GLOBAL: assert property (!global_irq_enable |-> req == '0)
    else $error("request without global flag");
  AST_LEVEL_WAKE: assert property (ext_pins[1] |-> !ext_level_wake[1])
    else $error("level wake with pin high");
  AST_LEVEL_REQ: assert property (ext_level_wake[0] [*2] ##0 global_irq_enable |-> req.ext_req[0])
    else $error("held low level gives no request");
  AST_WAKE_STILL: assert property ($stable(change_pins) [*2] |-> group_change_wake == 4'h0)
    else $error("change wake without change");
  AST_ACK_CLEARS: assert property ($stable(change_pins[7:0]) [*4] ##0 ack.group_ack[0] |=> !req.group_req[0])
    else $error("entry did not clear request");
endmodule

bind epi_unit epi_unit_sva chk_u (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .ext_pins(ext_pins), .change_pins(change_pins), .global_irq_enable(global_irq_enable), .ack(ack),
  .req(req), .ext_level_wake(ext_level_wake), .group_change_wake(group_change_wake));

// *** tb/epi_core_model.sv ***
// Core interrupt entry stand-in: takes the lowest pending source after a lag
module epi_core_model
  import epi_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic on, // Accepts vectors when high
  input wire logic [3:0] lag, // Cycles before entry
  input wire epi_pkg::epi_req_type req, // Pending requests
  output epi_pkg::epi_ack_type ack // One-cycle entry pulses
);
  logic [3:0] wait_q;
  // Gap after each entry lets the cleared flag drop its request first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= '0;
      wait_q <= 4'h0;
    end else if (on && req != '0 && ack == '0 && wait_q >= lag) begin
      ack <= req & (~req + 6'h01);
      wait_q <= 4'h0;
    end else begin
      ack <= '0;
      wait_q <= (req == '0) ? 4'h0 : wait_q + 4'h1;
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the pin interrupt unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import epi_pkg::*;
  logic clk = 0, rst_n = 0, gie = 0, on = 0;
  epi_bus_req_type bq = '0;
  epi_req_type rq;
  epi_ack_type ak;
  logic [7:0] rdata;
  logic [1:0] ep = 2'b11, lw;
  logic [27:0] cp = '0, msk;
  logic [3:0] lag = 4'h0, ge, gw;
  int err_count = 0, checked = 0, nacks = 0, m, i, r;
  initial forever #2 clk = ~clk;
  epi_unit dut_u (.clk(clk), .rst_n(rst_n), .bus_req(bq), .bus_rdata(rdata), .ext_pins(ep), .change_pins(cp),
    .global_irq_enable(gie), .ack(ak), .req(rq), .ext_level_wake(lw), .group_change_wake(gw));
  epi_core_model core_u (.clk(clk), .rst_n(rst_n), .on(on), .lag(lag), .req(rq), .ack(ak));
  always @(posedge clk) if ((|ak) === 1'b1) nacks++;
  function automatic logic [7:0] exp_flag(int md, bit rise);
    return 8'(md == 1 || (md == 2 && !rise) || (md == 3 && rise));
  endfunction
  function automatic logic [7:0] exp_grp(int p);
    return 8'(ge[p / 8] && msk[p]) << (p / 8);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  // One idle edge after each strobe so back-to-back calls never assign bq twice in a step
  task automatic wr(logic [3:0] a, logic [7:0] d);
    bq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bq <= '0;
    @(posedge clk);
  endtask
  // Read data is looked at mid-cycle, while it stands, clear of the edge race
  task automatic rd(logic [3:0] a, logic [7:0] e);
    bq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bq <= '0;
    @(negedge clk);
    chk("register", e, rdata);
    @(posedge clk);
  endtask
  initial begin
    r = $urandom(70);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i++) rd(i[3:0], 8'h00);
    msk = 28'($urandom);
    wr(OFS_MASK_GROUP0, msk[7:0]);
    wr(OFS_MASK_GROUP1, msk[15:8]);
    wr(OFS_MASK_GROUP2, msk[23:16]);
    wr(OFS_MASK_GROUP3, {4'hF, msk[27:24]});
    rd(OFS_MASK_GROUP3, {4'h0, msk[27:24]});
    rd(OFS_MASK_GROUP2, msk[23:16]);
    wr(OFS_IRQ_ENABLE, 8'hFC);
    rd(OFS_IRQ_ENABLE, 8'h00);
    // Each mode on each pin: falling then rising edge
    for (m = 0; m < 8; m++) begin
      i = m % 2;
      wr(OFS_SENSE_CONTROL, 8'((m / 2) << (i ? SENSE1_LSB : SENSE0_LSB)));
      wr(OFS_IRQ_FLAGS, 8'hFF);
      ep[i] <= 1'b0;
      repeat (4) @(posedge clk);
      wr(OFS_IRQ_FLAGS, 8'h00);
      rd(OFS_IRQ_FLAGS, exp_flag(m / 2, 0) << i);
      wr(OFS_IRQ_FLAGS, 8'hFF);
      ep[i] <= 1'b1;
      repeat (4) @(posedge clk);
      rd(OFS_IRQ_FLAGS, exp_flag(m / 2, 1) << i);
    end
    for (m = 0; m < 12; m++) begin
      ge = 4'($urandom);
      i = (m == 0) ? 27 : $urandom % 28;
      wr(OFS_GROUP_ENABLE, {4'hF, ge});
      wr(OFS_GROUP_FLAGS, 8'hFF);
      cp[i] <= ~cp[i];
      repeat (4) @(posedge clk);
      rd(OFS_GROUP_FLAGS, exp_grp(i));
    end
    wr(OFS_MASK_GROUP0, 8'hFF);
    wr(OFS_GROUP_ENABLE, 8'h01);
    wr(OFS_GROUP_FLAGS, 8'hFF);
    wr(OFS_SENSE_CONTROL, 8'h0A);
    wr(OFS_IRQ_FLAGS, 8'hFF);
    wr(OFS_IRQ_ENABLE, 8'h01);
    lag <= 4'($urandom % 8);
    on <= 1'b1;
    nacks = 0;
    ep <= 2'b00;
    cp[0] <= ~cp[0];
    repeat (4) @(posedge clk);
    rd(OFS_IRQ_FLAGS, 8'h03);
    gie <= 1'b1;
    for (r = 0; r < 40 && nacks < 2; r++) @(posedge clk);
    chk("entries", 8'd2, 8'(nacks));
    if (r == 40) report_and_stop();
    rd(OFS_IRQ_FLAGS, 8'h02);
    rd(OFS_GROUP_FLAGS, 8'h00);
    // Pins stay low through the level check
    wr(OFS_SENSE_CONTROL, 8'h00);
    repeat (4) @(posedge clk);
    rd(OFS_IRQ_FLAGS, 8'h00);
    ep <= 2'b11;
    report_and_stop();
  end
endmodule
